// [hdl/fepm_common.sv]
// Purpose: Common clock control, scaling accumulator, shared values, gen four pins
// Assumes: Source clocks arrive as enables on the single system clock
// Notes:   Registers on a plain port; read data one cycle after the strobe
`timescale 1ns/100ps
`include "fepm_cfg.svh"
module fepm_common #(
  parameter int NUM_GEN = 4
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  // Register port
  input  wire logic [3:0]         addr_in,
  input  wire fepm_pkg::fepm_word_t wdata_in,
  input  wire logic               wr_in,
  input  wire logic               rd_in,
  output logic [15:0]             rdata_out,
  // Source clock enables: osc, aux VCO half, primary PLL, aux PLL
  input  wire logic [3:0]         src_tick_in,
  // Fine-edge circuit status
  input  wire logic               fine_ready_in,
  input  wire logic               fine_fail_in,
  // Generator four raw outputs and state
  input  wire logic               gen_four_high_in,
  input  wire logic               gen_four_low_in,
  input  wire logic               gen_four_on_in,
  input  wire logic               high_output_pin_enable_in,
  input  wire logic               low_output_pin_enable_in,
  // Remappable routing of generator four and peripheral override
  input  wire logic               remap_high_sel_in,
  input  wire logic               remap_low_sel_in,
  input  wire logic [1:0]         periph_ovr_en_in,
  input  wire logic [1:0]         periph_ovr_val_in,
  input  wire logic [1:0]         remap_in_req_in,
  // Clocks and shared values to generators
  output logic                    pwm_clk_tick_out,
  output logic                    scaled_tick_out,
  output logic                    full_res_out,
  output logic [15:0]             shared_phase_out,
  output logic [15:0]             shared_duty_cycle_out,
  output logic [15:0]             shared_period_out,
  output logic                    lock_out,
  // Pins
  output logic                    gen_four_high_out,
  output logic                    gen_four_low_out,
  output logic                    gen_four_high_oe_out,
  output logic                    gen_four_low_oe_out,
  output logic                    remappable_pin_high_out,
  output logic                    remappable_pin_low_out,
  output logic                    remappable_pin_high_oe_out,
  output logic                    remappable_pin_low_oe_out,
  output logic [1:0]              remap_in_grant_out,
  output logic [NUM_GEN-1:0]      gen_present_out,
  // Interrupt
  output logic                    irq_out
);
  import fepm_pkg::*;

  // Register state
  fepm_key_state_t key_reg, key_next;
  logic       lock_reg, lock_next;
  logic [1:0] div_sel_reg, div_sel_next;
  logic [1:0] src_sel_reg, src_sel_next;
  logic       err_reg, err_next;
  logic       rdy_reg, rdy_next;
  logic       full_res_reg, full_res_next;
  fepm_word_t frequency_scale_step_reg, frequency_scale_step_next;
  fepm_word_t fsmin_reg, fsmin_next;
  fepm_word_t phase_reg, phase_next;
  fepm_word_t duty_reg, duty_next;
  fepm_word_t period_reg, period_next;
  logic [`FEPM_IRQ_WIDTH-1:0] ist_reg, ist_next;
  logic [`FEPM_IRQ_WIDTH-1:0] ien_reg, ien_next;
  logic [15:0] rdata_reg, rdata_next;
  // Clock path state
  logic [3:0] div_cnt_reg, div_cnt_next;
  logic       tick_reg, tick_next;
  logic [16:0] acc_reg, acc_next;
  logic       sc_tick_reg, sc_tick_next;
  // Pin state
  logic [9:0] pin_reg, pin_next;
  logic       irq_reg, irq_next;

  // Combinational helpers
  logic       src_tick;
  logic [3:0] div_last;
  logic [16:0] acc_sum;
  logic [`FEPM_IRQ_WIDTH-1:0] ev;
  logic       wr_open;

  // Generator presence flags
  genvar g;
  generate
    for (g = 0; g < NUM_GEN; g++) begin : g_present
      assign gen_present_out[g] = 1'b1; // [R17]
    end
  endgenerate

  // Source and divider selection
  always_comb begin
    src_tick = src_tick_in[src_sel_reg]; // [R11]
    unique case (div_sel_reg) // [R10]
      2'b00: div_last = 4'h1;
      2'b01: div_last = 4'h3;
      2'b10: div_last = 4'h7;
      2'b11: div_last = 4'hF;
    endcase
    acc_sum = acc_reg + {1'b0, frequency_scale_step_reg};
  end

  // Divider and scaling accumulator next state
  always_comb begin
    div_cnt_next = div_cnt_reg;
    tick_next    = 1'b0;
    acc_next     = acc_reg;
    sc_tick_next = 1'b0;
    if (src_tick) begin
      if (div_cnt_reg >= div_last) begin
        div_cnt_next = 4'h0;
        tick_next    = 1'b1;
      end else begin
        div_cnt_next = div_cnt_reg + 4'h1;
      end
    end
    if (tick_reg) begin
      if (acc_sum > {1'b0, fsmin_reg}) begin // [R12]
        acc_next     = acc_sum - {1'b0, fsmin_reg}; // [R18]
        sc_tick_next = 1'b1;
      end else begin
        acc_next = acc_sum;
      end
    end
  end

  // Register writes, key sequence and status
  always_comb begin
    key_next    = key_reg;
    lock_next   = lock_reg;
    div_sel_next = div_sel_reg;
    src_sel_next = src_sel_reg;
    frequency_scale_step_next   = frequency_scale_step_reg;
    fsmin_next  = fsmin_reg;
    phase_next  = phase_reg;
    duty_next   = duty_reg;
    period_next = period_reg;
    ien_next    = ien_reg;
    rdy_next    = fine_ready_in; // [R8]
    err_next    = err_reg | fine_fail_in; // [R9]
    full_res_next = rdy_next & ~err_next; // [R9]
    wr_open     = ~lock_reg; // [R2]
    ev[`FEPM_IRQ_READY] = fine_ready_in & ~rdy_reg;
    ev[`FEPM_IRQ_ERROR] = fine_fail_in & ~err_reg;
    ev[`FEPM_IRQ_PULSE] = sc_tick_reg;
    ist_next = ist_reg;
    if (wr_in) begin
      // Any write other than the next key drops the sequence
      key_next = FEPM_KEY_IDLE;
      unique case (addr_in)
        `FEPM_OFS_KEY: begin
          if (wdata_in[7:0] == `FEPM_KEY_FIRST) begin
            key_next = FEPM_KEY_GOT1; // [R1]
          end else if (wdata_in[7:0] == `FEPM_KEY_SECOND && key_reg == FEPM_KEY_GOT1) begin
            key_next = FEPM_KEY_OPEN; // [R1]
          end
        end
        `FEPM_OFS_CLKCON: begin
          if (key_reg == FEPM_KEY_OPEN) begin
            lock_next = wdata_in[`FEPM_BIT_LOCK]; // [R1] [R19]
          end
          if (wr_open) begin
            div_sel_next = wdata_in[5:4]; // [R16]
            src_sel_next = wdata_in[1:0];
          end
        end
        `FEPM_OFS_FREQUENCY_SCALE_STEP:   if (wr_open) frequency_scale_step_next = wdata_in;
        `FEPM_OFS_FSMIN:  if (wr_open) fsmin_next = wdata_in; // [R13]
        `FEPM_OFS_PHASE:  phase_next = wdata_in; // [R14]
        `FEPM_OFS_DUTY:   duty_next = wdata_in;
        `FEPM_OFS_PERIOD: period_next = wdata_in;
        `FEPM_OFS_INT_EN: ien_next = wdata_in[`FEPM_IRQ_WIDTH-1:0];
        `FEPM_OFS_INT_CLR: ist_next = ist_reg & ~wdata_in[`FEPM_IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
    ist_next = ist_next | ev; // Set wins over clear
    irq_next = |(ist_next & ien_next);
  end

  // Read mux, data one cycle after strobe
  always_comb begin
    rdata_next = 16'h0000;
    if (rd_in) begin
      unique case (addr_in)
        `FEPM_OFS_CLKCON: rdata_next = {rdy_reg, err_reg, 5'h00, lock_reg, // [R8] [R9]
                                        2'h0, div_sel_reg, 2'h0, src_sel_reg}; // [R16]
        `FEPM_OFS_FREQUENCY_SCALE_STEP:     rdata_next = frequency_scale_step_reg;
        `FEPM_OFS_FSMIN:    rdata_next = fsmin_reg;
        `FEPM_OFS_PHASE:    rdata_next = phase_reg;
        `FEPM_OFS_DUTY:     rdata_next = duty_reg;
        `FEPM_OFS_PERIOD:   rdata_next = period_reg;
        `FEPM_OFS_INT_STAT: rdata_next = {13'h0000, ist_reg};
        `FEPM_OFS_INT_EN:   rdata_next = {13'h0000, ien_reg};
        default:            rdata_next = 16'h0000;
      endcase
    end
  end

  // Pin routing for generator four
  always_comb begin
    // Dedicated high: peripheral override first, else gated PWM
    pin_next[0] = periph_ovr_en_in[0] ? periph_ovr_val_in[0] : gen_four_high_in; // [R6] [R4]
    pin_next[1] = periph_ovr_en_in[0] | high_output_pin_enable_in; // [R5]
    pin_next[2] = periph_ovr_en_in[1] ? periph_ovr_val_in[1] : gen_four_low_in; // [R6] [R4]
    pin_next[3] = periph_ovr_en_in[1] | low_output_pin_enable_in; // [R5]
    pin_next[4] = gen_four_high_in; // [R4]
    pin_next[5] = remap_high_sel_in & high_output_pin_enable_in; // [R5]
    pin_next[6] = gen_four_low_in;
    pin_next[7] = remap_low_sel_in & low_output_pin_enable_in; // [R5]
    pin_next[9:8] = gen_four_on_in ? 2'b00 : remap_in_req_in; // [R7]
  end

  // All state registers
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      key_reg     <= FEPM_KEY_IDLE;
      lock_reg    <= 1'b0; // [R19]
      div_sel_reg <= 2'b00;
      src_sel_reg <= 2'b00;
      err_reg     <= 1'b0;
      rdy_reg     <= 1'b0;
      full_res_reg <= 1'b0;
      frequency_scale_step_reg    <= 16'h0000;
      fsmin_reg   <= 16'h0000;
      phase_reg   <= 16'h0000;
      duty_reg    <= 16'h0000;
      period_reg  <= 16'h0000;
      ist_reg     <= '0;
      ien_reg     <= '0;
      rdata_reg   <= 16'h0000;
      div_cnt_reg <= 4'h0;
      tick_reg    <= 1'b0;
      acc_reg     <= 17'h00000;
      sc_tick_reg <= 1'b0;
      pin_reg     <= 10'h000;
      irq_reg     <= 1'b0;
    end else begin
      key_reg     <= key_next;
      lock_reg    <= lock_next;
      div_sel_reg <= div_sel_next;
      src_sel_reg <= src_sel_next;
      err_reg     <= err_next;
      rdy_reg     <= rdy_next;
      full_res_reg <= full_res_next;
      frequency_scale_step_reg    <= frequency_scale_step_next;
      fsmin_reg   <= fsmin_next;
      phase_reg   <= phase_next;
      duty_reg    <= duty_next;
      period_reg  <= period_next;
      ist_reg     <= ist_next;
      ien_reg     <= ien_next;
      rdata_reg   <= rdata_next;
      div_cnt_reg <= div_cnt_next;
      tick_reg    <= tick_next;
      acc_reg     <= acc_next;
      sc_tick_reg <= sc_tick_next;
      pin_reg     <= pin_next;
      irq_reg     <= irq_next;
    end
  end

  // Outputs straight from flops
  assign rdata_out                  = rdata_reg;
  assign pwm_clk_tick_out           = tick_reg;
  assign scaled_tick_out            = sc_tick_reg;
  assign full_res_out               = full_res_reg; // [R9]
  assign shared_phase_out           = phase_reg;
  assign shared_duty_cycle_out      = duty_reg;
  assign shared_period_out          = period_reg;
  assign lock_out                   = lock_reg;
  assign gen_four_high_out          = pin_reg[0];
  assign gen_four_high_oe_out       = pin_reg[1];
  assign gen_four_low_out           = pin_reg[2];
  assign gen_four_low_oe_out        = pin_reg[3];
  assign remappable_pin_high_out    = pin_reg[4];
  assign remappable_pin_high_oe_out = pin_reg[5];
  assign remappable_pin_low_out     = pin_reg[6];
  assign remappable_pin_low_oe_out  = pin_reg[7];
  assign remap_in_grant_out         = pin_reg[9:8];
  assign irq_out                    = irq_reg;
endmodule // fepm_common

// [hdl/fepm_cfg.svh]
// Purpose: Constants for the common clock and shared timebase block
// Assumes: 16-bit registers in the low bits of a plain register port
// Notes:   Each rule below except R3 and R15 is tagged where the logic or the bench carries it out
// Operation
// R1 - Lock bit changes only after key 0x55 then 0xAA, then one write.
// R2 - While lock is one, writes to protected registers and bits are ignored.
// R3 - Software should not change configuration or clock source while running.
// R4 - Generator four outputs drive dedicated and remappable pins together.
// R5 - High and low pin enables gate dedicated and remapped pins together.
// R6 - Remappable peripheral outputs override generator four on dedicated pins.
// R7 - Remappable inputs never reach dedicated pins while generator four active.
// R8 - Top bit of clock control shows fine-edge ready.
// R9 - Error bit set on fine-edge failure; full resolution needs ready, no error.
// R10 - Divider field: 11 is 1:16, 10 is 1:8, 01 is 1:4, 00 is 1:2.
// R11 - Source field: 11 aux PLL, 10 primary PLL, 01 aux VCO half, 00 osc.
// R12 - Each PWM clock adds step to accumulator; pulse when above min period.
// R13 - Sixteen-bit minimum-period register holds shortest scaled period.
// R14 - Shared phase, duty and period registers, read-write, reset to zero.
// R15 - Software must not program shared period below 0x0010.
// R16 - Unimplemented bits ignore writes and read as zero.
// R17 - First core instance has four generators, second has eight.
// R18 - On a pulse the minimum period is subtracted, keeping the remainder.
// R19 - Lock resets to zero; writes outside the key sequence leave it alone.
`ifndef FEPM_CFG_SVH
`define FEPM_CFG_SVH
// Register offsets
`define FEPM_OFS_CLKCON   4'h0
`define FEPM_OFS_FREQUENCY_SCALE_STEP     4'h1
`define FEPM_OFS_FSMIN    4'h2
`define FEPM_OFS_PHASE    4'h3
`define FEPM_OFS_DUTY     4'h4
`define FEPM_OFS_PERIOD   4'h5
`define FEPM_OFS_KEY      4'h6
`define FEPM_OFS_INT_STAT 4'h7
`define FEPM_OFS_INT_EN   4'h8
`define FEPM_OFS_INT_CLR  4'h9
// Clock control fields
`define FEPM_BIT_READY    15
`define FEPM_BIT_ERROR    14
`define FEPM_BIT_LOCK     8
`define FEPM_CLKCON_WMASK 16'h0033
// Unlock keys
`define FEPM_KEY_FIRST    8'h55
`define FEPM_KEY_SECOND   8'hAA
// Interrupt bits
`define FEPM_IRQ_READY    0
`define FEPM_IRQ_ERROR    1
`define FEPM_IRQ_PULSE    2
`define FEPM_IRQ_WIDTH    3
`endif

// [hdl/fepm_pkg.sv]
// Purpose: Types for the common clock and shared timebase block
// Assumes: fepm_cfg.svh holds the numbers
// Notes:   Key sequence states are one-hot
package fepm_pkg;
  typedef enum logic [2:0] {
    FEPM_KEY_IDLE = 3'b001,
    FEPM_KEY_GOT1 = 3'b010,
    FEPM_KEY_OPEN = 3'b100
  } fepm_key_state_t;
  typedef logic [15:0] fepm_word_t;
endpackage

// [sim/fepm_power_stage.sv]
// Purpose: Power stage switches hanging on the gen four pins
// Assumes: Gate drivers pull down, so a released pin turns its switch off
// Notes:   Gate order is dedicated high, dedicated low, remap high, remap low
`timescale 1ns/100ps
module fepm_power_stage (
  // Dedicated pins
  input  wire logic       ded_high_in,
  input  wire logic       ded_low_in,
  input  wire logic       ded_high_oe_in,
  input  wire logic       ded_low_oe_in,
  // Remappable pins
  input  wire logic       rmp_high_in,
  input  wire logic       rmp_low_in,
  input  wire logic       rmp_high_oe_in,
  input  wire logic       rmp_low_oe_in,
  // Switch states
  output logic      [3:0] gate_out
);
  // Undriven pin falls to the pull-down level
  assign gate_out = {ded_high_oe_in & ded_high_in, ded_low_oe_in & ded_low_in,
                     rmp_high_oe_in & rmp_high_in, rmp_low_oe_in & rmp_low_in};
endmodule // fepm_power_stage

// [sim/fepm_common_checker.sv]
// Purpose: Port assertions for the common clock block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into every fepm_common
`timescale 1ns/100ps
`include "fepm_cfg.svh"
module fepm_common_checker #(
  parameter int NUM_GEN = 4
) (
  // Clock, reset and register port
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  input wire logic [3:0]           addr_in,
  input wire fepm_pkg::fepm_word_t wdata_in,
  input wire logic                 wr_in,
  input wire logic                 rd_in,
  input wire logic [15:0]          rdata_out,
  // Gen four and pin controls
  input wire logic                 gen_four_on_in,
  input wire logic                 high_output_pin_enable_in,
  input wire logic                 remap_high_sel_in,
  input wire logic [1:0]           periph_ovr_en_in,
  input wire logic [1:0]           periph_ovr_val_in,
  // Outputs watched
  input wire logic                 pwm_clk_tick_out,
  input wire logic                 scaled_tick_out,
  input wire logic                 lock_out,
  input wire logic                 gen_four_high_out,
  input wire logic                 gen_four_high_oe_out,
  input wire logic                 remappable_pin_high_out,
  input wire logic                 remappable_pin_high_oe_out,
  input wire logic [1:0]           remap_in_grant_out
);
  import fepm_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Decoded key and clock control writes
  wire key1 = wr_in && addr_in == `FEPM_OFS_KEY && wdata_in[7:0] == `FEPM_KEY_FIRST;
  wire key2 = wr_in && addr_in == `FEPM_OFS_KEY && wdata_in[7:0] == `FEPM_KEY_SECOND;
  wire cw   = wr_in && addr_in == `FEPM_OFS_CLKCON;
  a_lock_moves_only: assert property (!$stable(lock_out) |->
    $past(cw) && $past(key2, 2) && $past(key1, 3)) else $error("lock moved outside keys");
  a_lock_takes_value: assert property (key1 ##1 key2 ##1 cw |=>
    lock_out == $past(wdata_in[`FEPM_BIT_LOCK])) else $error("lock write not taken");
  a_read_data_idle: assert property (rdata_out != 16'h0000 |-> $past(rd_in))
    else $error("read data outside read cycle");
  a_remap_same_drive: assert property ($past(remap_high_sel_in && !periph_ovr_en_in[0])
    |-> remappable_pin_high_out == gen_four_high_out) else $error("remap pin differs");
  a_pen_gates_both: assert property (!$past(high_output_pin_enable_in) |->
    !remappable_pin_high_oe_out && gen_four_high_oe_out == $past(periph_ovr_en_in[0]))
    else $error("pin enable gating wrong");
  a_periph_pin_wins: assert property ($past(periph_ovr_en_in[0]) |->
    gen_four_high_oe_out && gen_four_high_out == $past(periph_ovr_val_in[0]))
    else $error("peripheral override lost");
  a_no_remap_input: assert property ($past(gen_four_on_in) |->
    remap_in_grant_out == 2'h0) else $error("input granted while active");
  a_scale_after_tick: assert property (scaled_tick_out |-> $past(pwm_clk_tick_out) ||
    $past(pwm_clk_tick_out, 2) || $past(pwm_clk_tick_out, 3)) else $error("stray scaled tick");
endmodule // fepm_common_checker
bind fepm_common fepm_common_checker #(.NUM_GEN(NUM_GEN)) u_checker (.clk_in, .rst_n_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .gen_four_on_in, .high_output_pin_enable_in,
  .remap_high_sel_in, .periph_ovr_en_in, .periph_ovr_val_in, .pwm_clk_tick_out,
  .scaled_tick_out, .lock_out, .gen_four_high_out, .gen_four_high_oe_out,
  .remappable_pin_high_out, .remappable_pin_high_oe_out, .remap_in_grant_out);

// [sim/fepm_common_tb.sv]
// Purpose: Register-level bench for the common clock block
// Assumes: Read data one cycle after the strobe, writes land next cycle
// Notes:   Power stage model observes the gen four pins
`timescale 1ns/100ps
`include "fepm_cfg.svh"
module fepm_common_tb;
  import fepm_pkg::*;
  // Design inputs
  logic       clk_in = 1'h0, rst_n_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0;
  logic [3:0] addr_in = 4'h0, src_tick_in = 4'h0;
  fepm_word_t wdata_in = 16'h0000;
  logic       fine_ready_in = 1'h0, fine_fail_in = 1'h0, gen_four_on_in = 1'h0;
  logic       gen_four_high_in = 1'h0, gen_four_low_in = 1'h0;
  logic       high_output_pin_enable_in = 1'h0, low_output_pin_enable_in = 1'h0;
  logic       remap_high_sel_in = 1'h0, remap_low_sel_in = 1'h0;
  logic [1:0] periph_ovr_en_in = 2'h0, periph_ovr_val_in = 2'h0, remap_in_req_in = 2'h0;
  // Design and partner outputs
  logic [15:0] rdata_out, shared_phase_out, shared_duty_cycle_out, shared_period_out;
  logic        pwm_clk_tick_out, scaled_tick_out, full_res_out, lock_out, irq_out;
  logic        gen_four_high_out, gen_four_low_out, gen_four_high_oe_out, gen_four_low_oe_out;
  logic        remappable_pin_high_out, remappable_pin_low_out;
  logic        remappable_pin_high_oe_out, remappable_pin_low_oe_out;
  logic [1:0]  remap_in_grant_out;
  logic [3:0]  gen_present_out, gate_out;
  int          fails = 0, n_tests = 0, cyc = 0, cnt;
  fepm_common #(.NUM_GEN(4)) dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .src_tick_in, .fine_ready_in, .fine_fail_in, .gen_four_high_in,
    .gen_four_low_in, .gen_four_on_in, .high_output_pin_enable_in, .low_output_pin_enable_in,
    .remap_high_sel_in, .remap_low_sel_in, .periph_ovr_en_in, .periph_ovr_val_in,
    .remap_in_req_in, .pwm_clk_tick_out, .scaled_tick_out, .full_res_out, .shared_phase_out,
    .shared_duty_cycle_out, .shared_period_out, .lock_out, .gen_four_high_out,
    .gen_four_low_out, .gen_four_high_oe_out, .gen_four_low_oe_out, .remappable_pin_high_out,
    .remappable_pin_low_out, .remappable_pin_high_oe_out, .remappable_pin_low_oe_out,
    .remap_in_grant_out, .gen_present_out, .irq_out);
  fepm_power_stage u_stage (.ded_high_in(gen_four_high_out), .ded_low_in(gen_four_low_out),
    .ded_high_oe_in(gen_four_high_oe_out), .ded_low_oe_in(gen_four_low_oe_out),
    .rmp_high_in(remappable_pin_high_out), .rmp_low_in(remappable_pin_low_out),
    .rmp_high_oe_in(remappable_pin_high_oe_out), .rmp_low_oe_in(remappable_pin_low_oe_out),
    .gate_out);
  // 40 MHz clock
  initial forever #12.5 clk_in = ~clk_in;
  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    wr_in <= 1'h1;
    rd_in <= 1'h0;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    rd_in <= 1'h1;
    wr_in <= 1'h0;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'h0;
    #1 chk(rdata_out, e);
  endtask
  task automatic idle(input int n);
    wr_in <= 1'h0;
    rd_in <= 1'h0;
    repeat (n) @(posedge clk_in);
  endtask
  // Counts scaled or divided ticks over n cycles
  task automatic count(input int n, input bit sc, output int c);
    c = 0;
    repeat (n) begin
      @(posedge clk_in);
      #1 c += ((sc ? scaled_tick_out : pwm_clk_tick_out) === 1'h1);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'h1;
    for (int a = 0; a < 16; a++) rd(a[3:0], 16'h0000);
    chk({12'h000, gen_present_out}, 16'h000F);
    $display("reset values done");
    for (int a = 0; a < 6; a++) wr(a[3:0], 16'hFFFF);
    for (int a = 0; a < 6; a++) rd(a[3:0], a == 0 ? 16'h0033 : 16'hFFFF);
    chk(shared_period_out, 16'hFFFF);
    chk(shared_duty_cycle_out, 16'hFFFF);
    $display("access done");
    // Unlock, locked writes, broken sequence, unlock again
    wr(`FEPM_OFS_KEY, 16'h0055);
    wr(`FEPM_OFS_KEY, 16'h00AA);
    wr(`FEPM_OFS_CLKCON, 16'h0111);
    wr(`FEPM_OFS_FREQUENCY_SCALE_STEP, 16'h0F0F);
    wr(`FEPM_OFS_CLKCON, 16'h0000);
    rd(`FEPM_OFS_CLKCON, 16'h0111);
    rd(`FEPM_OFS_FREQUENCY_SCALE_STEP, 16'hFFFF);
    wr(`FEPM_OFS_KEY, 16'h0055);
    wr(`FEPM_OFS_PHASE, 16'h00AA);
    wr(`FEPM_OFS_KEY, 16'h00AA);
    wr(`FEPM_OFS_CLKCON, 16'h0000);
    rd(`FEPM_OFS_PHASE, 16'h00AA);
    chk(shared_phase_out, 16'h00AA);
    rd(`FEPM_OFS_CLKCON, 16'h0111);
    wr(`FEPM_OFS_KEY, 16'h0055);
    wr(`FEPM_OFS_KEY, 16'h00AA);
    wr(`FEPM_OFS_CLKCON, 16'h0000);
    wr(`FEPM_OFS_PERIOD, 16'h0010);
    rd(`FEPM_OFS_CLKCON, 16'h0011);
    chk(lock_out, 1'h0);
    $display("lock done");
    // Each divide ratio from each source, with the generator off
    for (int d = 0; d < 4; d++) for (int s = 0; s < 4; s++) begin
      wr(`FEPM_OFS_CLKCON, {10'h000, d[1:0], 2'h0, s[1:0]});
      src_tick_in <= 4'h1 << s;
      idle(40);
      count(64, 1'b0, cnt);
      chk(cnt[15:0], 16'(64 >> (d + 1)));
    end
    $display("divider done");
    // Mid-run reset clears the accumulator left large by the divider runs
    rst_n_in <= 1'h0;
    idle(3);
    chk(shared_period_out, 16'h0000);
    rst_n_in <= 1'h1;
    // Scaler: step 3 over minimum 7 at 1:2 gives 150 pulses in 700 cycles
    wr(`FEPM_OFS_CLKCON, 16'h0000);
    src_tick_in <= 4'h1;
    wr(`FEPM_OFS_FSMIN, 16'h0007);
    wr(`FEPM_OFS_FREQUENCY_SCALE_STEP, 16'h0003);
    wr(`FEPM_OFS_INT_EN, 16'h0004);
    idle(40);
    count(700, 1'b1, cnt);
    chk(16'(cnt >= 149 && cnt <= 151), 16'h0001);
    chk(irq_out, 1'h1);
    rd(`FEPM_OFS_INT_STAT, 16'h0004);
    wr(`FEPM_OFS_FREQUENCY_SCALE_STEP, 16'h0000);
    idle(8);
    wr(`FEPM_OFS_INT_CLR, 16'h0007);
    rd(`FEPM_OFS_INT_STAT, 16'h0000);
    chk(irq_out, 1'h0);
    $display("scaler done");
    // Ready, masking, then a sticky error
    fine_ready_in <= 1'h1;
    idle(8);
    rd(`FEPM_OFS_CLKCON, 16'h8000);
    chk(full_res_out, 1'h1);
    rd(`FEPM_OFS_INT_STAT, 16'h0001);
    wr(`FEPM_OFS_INT_EN, 16'h0001);
    idle(3);
    chk(irq_out, 1'h1);
    wr(`FEPM_OFS_INT_EN, 16'h0000);
    idle(3);
    chk(irq_out, 1'h0);
    fine_fail_in <= 1'h1;
    idle(2);
    fine_fail_in <= 1'h0;
    idle(8);
    rd(`FEPM_OFS_CLKCON, 16'hC000);
    chk(full_res_out, 1'h0);
    $display("status done");
    // Gen four on both pin sets, then gated, then overridden
    gen_four_high_in <= 1'h1;
    gen_four_on_in <= 1'h1;
    high_output_pin_enable_in <= 1'h1;
    low_output_pin_enable_in <= 1'h1;
    remap_high_sel_in <= 1'h1;
    remap_low_sel_in <= 1'h1;
    remap_in_req_in <= 2'h3;
    idle(3);
    chk(gate_out, 4'hA);
    chk(remap_in_grant_out, 2'h0);
    high_output_pin_enable_in <= 1'h0;
    low_output_pin_enable_in <= 1'h0;
    idle(3);
    chk(gate_out, 4'h0);
    high_output_pin_enable_in <= 1'h1;
    periph_ovr_en_in <= 2'h1;
    idle(3);
    chk(gate_out, 4'h2);
    gen_four_on_in <= 1'h0;
    idle(3);
    chk(remap_in_grant_out, 2'h3);
    $display("pins done");
    end_of_test();
  end
endmodule // fepm_common_tb
